// ===== rtl/port_pin_control.v
// port pin control: four ports of 8, 8, 5 and 2 pins with per-pin driver type selection
// assumes a plain register port on clock, pins sampled through two flip-flops
// Summary of operation
// RULE1 - four ports exist, ports 0 and 1 with eight pins, port 2 with five and port 3 with two.
// RULE2 - each configurable pin picks quasi, push-pull, open-drain or input-only from two config registers per port.
// RULE3 - the reset-capable pin of port 1 stays input-only whatever software writes.
// RULE4 - the two serial-bus pins of port 1 can only be input-only or open-drain.
// RULE5 - quasi type drives high weakly and low strongly so the pin still works as an input.
// RULE6 - open-drain turns off pull-ups and drives low only while the latch holds zero.
// RULE7 - input-only disables both drivers and leaves the input readable.
// RULE8 - push-pull drives low as open-drain and drives high strongly while the latch holds one.
// RULE9 - software using a pin for a comparator selects input-only to disable its output.
// RULE10 - port 0 pins 1 to 5 have their digital input gated by the analog-disable bits, cleared on reset.
// RULE11 - every pin is input-only after reset until software configures it.
// RULE12 - the reset-capable pin is an active-low reset input when the reset pin enable bit is one, else an input.
// RULE13 - a pin's driver type is the pair of matching bits from the two config registers.
`default_nettype none

module port_pin_control (
    input  wire        clock,          // core clock, 200 MHz
    input  wire        resetn,         // synchronous reset, active low
    input  wire [7:0]  addr,           // register address
    input  wire [7:0]  wdata,          // write data
    input  wire        wr,             // write strobe
    input  wire        rd,             // read strobe
    output reg  [7:0]  rdata,          // read data, cycle after rd
    input  wire [7:0]  p0_in,          // port 0 pin levels
    output wire [7:0]  p0_out,         // port 0 drive level
    output wire [7:0]  p0_oe,          // port 0 strong drive enable
    output wire [7:0]  p0_weak_pu,     // port 0 weak pull-up enable
    input  wire [7:0]  p1_in,          // port 1 pin levels
    output wire [7:0]  p1_out,         // port 1 drive level
    output wire [7:0]  p1_oe,          // port 1 strong drive enable
    output wire [7:0]  p1_weak_pu,     // port 1 weak pull-up enable
    input  wire [4:0]  p2_in,          // port 2 pin levels
    output wire [4:0]  p2_out,         // port 2 drive level
    output wire [4:0]  p2_oe,          // port 2 strong drive enable
    output wire [4:0]  p2_weak_pu,     // port 2 weak pull-up enable
    input  wire [1:0]  p3_in,          // port 3 pin levels
    output wire [1:0]  p3_out,         // port 3 drive level
    output wire [1:0]  p3_oe,          // port 3 strong drive enable
    output wire [1:0]  p3_weak_pu,     // port 3 weak pull-up enable
    output wire        ext_reset_req   // external reset request from pin, active high
);

`include "port_pin_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] p0_cfg_a_reg;
reg [7:0] p0_cfg_b_reg;
reg [7:0] p1_cfg_a_reg;
reg [7:0] p1_cfg_b_reg;
reg [4:0] p2_cfg_a_reg;
reg [4:0] p2_cfg_b_reg;
reg [1:0] p3_cfg_a_reg;
reg [1:0] p3_cfg_b_reg;
reg [7:0] p0_latch_reg;
reg [7:0] p1_latch_reg;
reg [4:0] p2_latch_reg;
reg [1:0] p3_latch_reg;
reg [7:0] ana_dis_reg;
reg       rpe_reg;

// full-width reset patterns, sliced on purpose for the narrow ports
localparam [7:0] RST_A_FULL = `RST_CFG_A;
localparam [7:0] RST_B_FULL = `RST_CFG_B;
localparam [7:0] RST_L_FULL = `RST_LATCH;
localparam [7:0] RST_U_FULL = `RST_USER_CFG1;

// serial pins accept input-only or open-drain only: force cfg_a high on them
function [7:0] p1_cfg_a_fix;
    input [7:0] v;
    begin
        p1_cfg_a_fix = v;
        p1_cfg_a_fix[`POS_SCL_PIN] = 1'b1;     // [RULE4]
        p1_cfg_a_fix[`POS_SDA_PIN] = 1'b1;     // [RULE4]
        p1_cfg_a_fix[`POS_RESET_PIN] = 1'b1;   // [RULE3]
    end
endfunction

// serial pins keep any cfg_b bit: with cfg_a forced high it only picks input-only or open-drain
function [7:0] p1_cfg_b_fix;
    input [7:0] v;
    begin
        p1_cfg_b_fix = v;
        p1_cfg_b_fix[`POS_RESET_PIN] = 1'b0;   // [RULE3]
    end
endfunction

always @(posedge clock) begin
    if (!resetn) begin
        // all pins input-only out of reset
        p0_cfg_a_reg <= `RST_CFG_A;            // [RULE11]
        p0_cfg_b_reg <= `RST_CFG_B;            // [RULE11]
        p1_cfg_a_reg <= `RST_CFG_A;
        p1_cfg_b_reg <= `RST_CFG_B;
        p2_cfg_a_reg <= RST_A_FULL[4:0];
        p2_cfg_b_reg <= RST_B_FULL[4:0];
        p3_cfg_a_reg <= RST_A_FULL[1:0];
        p3_cfg_b_reg <= RST_B_FULL[1:0];
        p0_latch_reg <= `RST_LATCH;
        p1_latch_reg <= `RST_LATCH;
        p2_latch_reg <= RST_L_FULL[4:0];
        p3_latch_reg <= RST_L_FULL[1:0];
        ana_dis_reg  <= `RST_ANA_DIS;          // [RULE10]
        rpe_reg      <= RST_U_FULL[`POS_RPE];
    end else if (wr) begin
        if (addr == `OFS_P0_CFG_A) begin
            p0_cfg_a_reg <= wdata;             // [RULE2]
        end else if (addr == `OFS_P0_CFG_B) begin
            p0_cfg_b_reg <= wdata;             // [RULE2]
        end else if (addr == `OFS_P1_CFG_A) begin
            p1_cfg_a_reg <= p1_cfg_a_fix(wdata);
        end else if (addr == `OFS_P1_CFG_B) begin
            p1_cfg_b_reg <= p1_cfg_b_fix(wdata);
        end else if (addr == `OFS_P2_CFG_A) begin
            p2_cfg_a_reg <= wdata[4:0];
        end else if (addr == `OFS_P2_CFG_B) begin
            p2_cfg_b_reg <= wdata[4:0];
        end else if (addr == `OFS_P3_CFG_A) begin
            p3_cfg_a_reg <= wdata[1:0];
        end else if (addr == `OFS_P3_CFG_B) begin
            p3_cfg_b_reg <= wdata[1:0];
        end else if (addr == `OFS_P0_LATCH) begin
            p0_latch_reg <= wdata;
        end else if (addr == `OFS_P1_LATCH) begin
            p1_latch_reg <= wdata;
        end else if (addr == `OFS_P2_LATCH) begin
            p2_latch_reg <= wdata[4:0];
        end else if (addr == `OFS_P3_LATCH) begin
            p3_latch_reg <= wdata[1:0];
        end else if (addr == `OFS_P0_ANA_DIS) begin
            ana_dis_reg <= wdata & `MASK_ANA_DIS;   // [RULE10]
        end else if (addr == `OFS_USER_CFG1) begin
            rpe_reg <= wdata[`POS_RPE];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin input synchronisers

reg [22:0] in_meta_reg;
reg [22:0] in_sync_reg;

always @(posedge clock) begin
    if (!resetn) begin
        in_meta_reg <= 23'h000000;
        in_sync_reg <= 23'h000000;
    end else begin
        in_meta_reg <= {p3_in, p2_in, p1_in, p0_in};
        in_sync_reg <= in_meta_reg;
    end
end

wire [7:0] p0_sync = in_sync_reg[7:0];
wire [7:0] p1_sync = in_sync_reg[15:8];
wire [4:0] p2_sync = in_sync_reg[20:16];
wire [1:0] p3_sync = in_sync_reg[22:21];

// analog pins read zero so a mid-level voltage cannot toggle logic downstream
wire [7:0] p0_digital = p0_sync & ~ana_dis_reg;   // [RULE10]

// pin is an active-low reset only while enabled; otherwise a plain input
assign ext_reset_req = rpe_reg & ~p1_sync[`POS_RESET_PIN];   // [RULE12]

////////////////////////////////////////////////////////////////////////////////
// read port

always @(posedge clock) begin
    if (!resetn) begin
        rdata <= 8'h00;
    end else if (rd) begin
        if (addr == `OFS_P0_CFG_A) begin
            rdata <= p0_cfg_a_reg;
        end else if (addr == `OFS_P0_CFG_B) begin
            rdata <= p0_cfg_b_reg;
        end else if (addr == `OFS_P1_CFG_A) begin
            rdata <= p1_cfg_a_reg;
        end else if (addr == `OFS_P1_CFG_B) begin
            rdata <= p1_cfg_b_reg;
        end else if (addr == `OFS_P2_CFG_A) begin
            rdata <= {3'h0, p2_cfg_a_reg};
        end else if (addr == `OFS_P2_CFG_B) begin
            rdata <= {3'h0, p2_cfg_b_reg};
        end else if (addr == `OFS_P3_CFG_A) begin
            rdata <= {6'h00, p3_cfg_a_reg};
        end else if (addr == `OFS_P3_CFG_B) begin
            rdata <= {6'h00, p3_cfg_b_reg};
        end else if (addr == `OFS_P0_LATCH) begin
            rdata <= p0_latch_reg;
        end else if (addr == `OFS_P1_LATCH) begin
            rdata <= p1_latch_reg;
        end else if (addr == `OFS_P2_LATCH) begin
            rdata <= {3'h0, p2_latch_reg};
        end else if (addr == `OFS_P3_LATCH) begin
            rdata <= {6'h00, p3_latch_reg};
        end else if (addr == `OFS_P0_IN) begin
            rdata <= p0_digital;
        end else if (addr == `OFS_P1_IN) begin
            rdata <= p1_sync;                  // [RULE7]
        end else if (addr == `OFS_P2_IN) begin
            rdata <= {3'h0, p2_sync};
        end else if (addr == `OFS_P3_IN) begin
            rdata <= {6'h00, p3_sync};
        end else if (addr == `OFS_P0_ANA_DIS) begin
            rdata <= ana_dis_reg;
        end else if (addr == `OFS_USER_CFG1) begin
            rdata <= {7'h00, rpe_reg};
        end else begin
            rdata <= 8'h00;
        end
    end else begin
        rdata <= 8'h00;
    end
end

////////////////////////////////////////////////////////////////////////////////
// drivers, one instance per port

pin_driver #(.WIDTH(8)) u_p0 (               // [RULE1]
    .cfg_a   (p0_cfg_a_reg),
    .cfg_b   (p0_cfg_b_reg),
    .latch   (p0_latch_reg),
    .pin_out (p0_out),
    .pin_oe  (p0_oe),
    .weak_pu (p0_weak_pu)
);

pin_driver #(.WIDTH(8)) u_p1 (               // [RULE1]
    .cfg_a   (p1_cfg_a_reg),
    .cfg_b   (p1_cfg_b_reg),
    .latch   (p1_latch_reg),
    .pin_out (p1_out),
    .pin_oe  (p1_oe),
    .weak_pu (p1_weak_pu)
);

pin_driver #(.WIDTH(5)) u_p2 (               // [RULE1]
    .cfg_a   (p2_cfg_a_reg),
    .cfg_b   (p2_cfg_b_reg),
    .latch   (p2_latch_reg),
    .pin_out (p2_out),
    .pin_oe  (p2_oe),
    .weak_pu (p2_weak_pu)
);

pin_driver #(.WIDTH(2)) u_p3 (               // [RULE1]
    .cfg_a   (p3_cfg_a_reg),
    .cfg_b   (p3_cfg_b_reg),
    .latch   (p3_latch_reg),
    .pin_out (p3_out),
    .pin_oe  (p3_oe),
    .weak_pu (p3_weak_pu)
);

endmodule

`default_nettype wire

// ===== shared/port_pin_defs.vh
// constants for the port pin control block: register offsets, field positions, reset values
// assumes inclusion by bare name from rtl files
`ifndef PORT_PIN_DEFS_VH
`define PORT_PIN_DEFS_VH

// register offsets (byte addresses on the plain register port)
`define OFS_P0_CFG_A      8'h00
`define OFS_P0_CFG_B      8'h01
`define OFS_P1_CFG_A      8'h02
`define OFS_P1_CFG_B      8'h03
`define OFS_P2_CFG_A      8'h04
`define OFS_P2_CFG_B      8'h05
`define OFS_P3_CFG_A      8'h06
`define OFS_P3_CFG_B      8'h07
`define OFS_P0_LATCH      8'h08
`define OFS_P1_LATCH      8'h09
`define OFS_P2_LATCH      8'h0A
`define OFS_P3_LATCH      8'h0B
`define OFS_P0_IN         8'h0C
`define OFS_P1_IN         8'h0D
`define OFS_P2_IN         8'h0E
`define OFS_P3_IN         8'h0F
`define OFS_P0_ANA_DIS    8'h10
`define OFS_USER_CFG1     8'h11

// driver type codes {cfg_a bit, cfg_b bit}
`define TYPE_QUASI        2'h0
`define TYPE_PUSH_PULL    2'h1
`define TYPE_INPUT_ONLY   2'h2
`define TYPE_OPEN_DRAIN   2'h3

// reset values: input-only means cfg_a=1, cfg_b=0
`define RST_CFG_A         8'hFF
`define RST_CFG_B         8'h00
`define RST_LATCH         8'hFF
`define RST_ANA_DIS       8'h00
`define RST_USER_CFG1     8'h00

// field positions
`define POS_RESET_PIN     5
`define POS_SCL_PIN       2
`define POS_SDA_PIN       3
`define POS_RPE           0
`define MASK_ANA_DIS      8'h3E
`define MASK_P2           8'h1F
`define MASK_P3           8'h03

`endif

// ===== rtl/pin_driver.v
// one port's pin drivers: decodes the per-pin driver type into output enables
// assumes cfg and latch come from registers on the same clock
`default_nettype none

module pin_driver #(
    parameter WIDTH = 8
) (
    input  wire [WIDTH-1:0] cfg_a,     // config register a
    input  wire [WIDTH-1:0] cfg_b,     // config register b
    input  wire [WIDTH-1:0] latch,     // output latch
    output wire [WIDTH-1:0] pin_out,   // level driven
    output wire [WIDTH-1:0] pin_oe,    // strong drive enable
    output wire [WIDTH-1:0] weak_pu    // weak pull-up enable
);

`include "port_pin_defs.vh"

genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
        wire [1:0] kind = {cfg_a[i], cfg_b[i]};   // [RULE13]
        // low is strong in every driving type
        wire drv_low = ~latch[i] & (kind != `TYPE_INPUT_ONLY);         // [RULE5] [RULE6] [RULE8]
        wire drv_high = latch[i] & (kind == `TYPE_PUSH_PULL);          // [RULE8]
        assign pin_out[i] = latch[i];
        assign pin_oe[i]  = drv_low | drv_high;                        // [RULE6] [RULE7]
        assign weak_pu[i] = latch[i] & (kind == `TYPE_QUASI);          // [RULE5]
    end
endgenerate

endmodule

`default_nettype wire

// ===== verification/port_pin_control_sva.sv
// checker for the port pin control block: pin drive relations and register side effects
// assumes a bind onto port_pin_control, one clock, synchronous active-low reset
`default_nettype none
`include "port_pin_defs.vh"

module port_pin_control_sva (
    input wire logic       clock,          // core clock
    input wire logic       resetn,         // synchronous reset, active low
    input wire logic [7:0] addr,           // register address
    input wire logic [7:0] wdata,          // write data
    input wire logic       wr,             // write strobe
    input wire logic [7:0] p0_out,         // port 0 drive level
    input wire logic [7:0] p0_oe,          // port 0 strong enable
    input wire logic [7:0] p0_weak_pu,     // port 0 weak pull-up
    input wire logic [7:0] p1_in,          // port 1 pin levels
    input wire logic [7:0] p1_out,         // port 1 drive level
    input wire logic [7:0] p1_oe,          // port 1 strong enable
    input wire logic [7:0] p1_weak_pu,     // port 1 weak pull-up
    input wire logic [4:0] p2_oe,          // port 2 strong enable
    input wire logic [1:0] p3_oe,          // port 3 strong enable
    input wire logic       ext_reset_req   // reset request from pin
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_cfg_a_all;
        wr && addr == `OFS_P0_CFG_A && wdata == 8'hFF;
    endsequence
    sequence s_cfg_b_none;
        wr && addr == `OFS_P0_CFG_B && wdata == 8'h00;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_reset_all_idle: assert property ($rose(resetn) |-> (p0_oe | p1_oe | p2_oe | p3_oe) == 8'h00)
        else $error("pin driven right after reset");
    a_reset_pin_quiet: assert property (!p1_oe[5] && !p1_weak_pu[5])
        else $error("reset-capable pin driven");
    a_serial_never_high: assert property ((p1_oe[3:2] & p1_out[3:2]) == 2'h0 && p1_weak_pu[3:2] == 2'h0)
        else $error("serial shared pin pulled high");
    a_weak_not_strong: assert property ((p0_oe & p0_weak_pu) == 8'h00)
        else $error("weak and strong drive together");
    a_weak_only_high: assert property ((p0_weak_pu & ~p0_out) == 8'h00)
        else $error("weak pull-up with latch low");
    a_latch_follows: assert property (wr && addr == `OFS_P0_LATCH |=> p0_out == $past(wdata))
        else $error("latch write not seen on drive level");
    a_input_only_seq: assert property (s_cfg_a_all ##1 !wr ##1 s_cfg_b_none |=> p0_oe == 8'h00 && p0_weak_pu == 8'h00)
        else $error("input-only still drives");
    a_ext_reset_src: assert property (ext_reset_req |-> $past(p1_in[5], 2) == 1'b0)
        else $error("reset request without low pin");
endmodule

bind port_pin_control port_pin_control_sva u_sva (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .p0_out(p0_out), .p0_oe(p0_oe), .p0_weak_pu(p0_weak_pu), .p1_in(p1_in), .p1_out(p1_out),
    .p1_oe(p1_oe), .p1_weak_pu(p1_weak_pu), .p2_oe(p2_oe), .p3_oe(p3_oe), .ext_reset_req(ext_reset_req));
`default_nettype wire

// ===== verification/pin_board_model.sv
// board side of one port: external pull-up resistors plus parts that may pull pins low
// assumes strong drive wins over any external part
`default_nettype none

module pin_board_model #(
    parameter int W = 8,
    parameter logic [W-1:0] BOARD_PU = '1    // pins with a board pull-up fitted
) (
    input  wire logic [W-1:0] out,      // drive level
    input  wire logic [W-1:0] oe,       // strong enable
    input  wire logic [W-1:0] weak_pu,  // weak pull-up, overpowered by ext_low
    input  wire logic [W-1:0] ext_low,  // external part pulling low
    output var  logic [W-1:0] level     // resolved pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    // released or weak pins go to the board pull-up unless a part sinks them
    assign level = (oe & out) | (~oe & ~ext_low & (weak_pu | BOARD_PU));
endmodule
`default_nettype wire

// ===== verification/tb_port_pin_control.sv
// testbench for the port pin control block: register calls, pin checks, reset pin
// assumes the board model on every port and the checker bound to the design
`default_nettype none
`include "port_pin_defs.vh"

module tb_port_pin_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, resetn = 0, wr = 0, rd = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, x0 = 8'h00, x1 = 8'h00;
    logic [4:0] x2 = 5'h00;
    logic [1:0] x3 = 2'h0;
    wire logic [7:0] rdata, p0_in, p0_out, p0_oe, p0_pu, p1_in, p1_out, p1_oe, p1_pu;
    wire logic [4:0] p2_in, p2_out, p2_oe, p2_pu;
    wire logic [1:0] p3_in, p3_out, p3_oe, p3_pu;
    wire logic       ext_req;
    int fails = 0, total_checks = 0, cycles = 0;

    port_pin_control u_dut (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe), .p0_weak_pu(p0_pu),
        .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe), .p1_weak_pu(p1_pu), .p2_in(p2_in), .p2_out(p2_out),
        .p2_oe(p2_oe), .p2_weak_pu(p2_pu), .p3_in(p3_in), .p3_out(p3_out), .p3_oe(p3_oe),
        .p3_weak_pu(p3_pu), .ext_reset_req(ext_req));
    pin_board_model #(.W(8)) u_b0 (.out(p0_out), .oe(p0_oe), .weak_pu(p0_pu), .ext_low(x0), .level(p0_in));
    pin_board_model #(.W(8)) u_b1 (.out(p1_out), .oe(p1_oe), .weak_pu(p1_pu), .ext_low(x1), .level(p1_in));
    pin_board_model #(.W(5)) u_b2 (.out(p2_out), .oe(p2_oe), .weak_pu(p2_pu), .ext_low(x2), .level(p2_in));
    pin_board_model #(.W(2)) u_b3 (.out(p3_out), .oe(p3_oe), .weak_pu(p3_pu), .ext_low(x3), .level(p3_in));

    initial begin
        forever #2.5 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t read got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t pins got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        cmp_reg(rdata, exp);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // bound on the whole run; the sequence needs under a hundred cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            fails++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        rd_chk(`OFS_P0_CFG_A, 8'hFF);
        rd_chk(`OFS_P0_CFG_B, 8'h00);
        rd_chk(`OFS_P0_ANA_DIS, 8'h00);
        rd_chk(`OFS_USER_CFG1, 8'h00);
        rd_chk(`OFS_P2_CFG_A, 8'h1F);
        rd_chk(`OFS_P3_CFG_A, 8'h03);
        rd_chk(8'h20, 8'h00);
        cmp_pin(p0_oe | p1_oe | p0_pu | p1_pu | p2_oe | p2_pu | p3_oe | p3_pu, 8'h00);
        $display("test reset values done");
        wr_reg(`OFS_P0_CFG_A, 8'hCC);
        wr_reg(`OFS_P0_CFG_B, 8'hAA);
        wr_reg(`OFS_P0_LATCH, 8'hF0);
        cmp_pin(p0_oe, 8'h2B);
        cmp_pin(p0_pu, 8'h10);
        cmp_pin(p0_out, 8'hF0);
        $display("test four types done");
        wr_reg(`OFS_P1_CFG_A, 8'h00);
        wr_reg(`OFS_P1_CFG_B, 8'hFF);
        wr_reg(`OFS_P1_LATCH, 8'h00);
        cmp_pin(p1_oe, 8'hDF);
        wr_reg(`OFS_P1_LATCH, 8'hFF);
        cmp_pin(p1_oe, 8'hD3);
        cmp_pin(p1_out, 8'hFF);
        cmp_pin(p1_pu, 8'h00);
        rd_chk(`OFS_P1_CFG_A, 8'h2C);
        rd_chk(`OFS_P1_CFG_B, 8'hDF);
        wr_reg(`OFS_P2_CFG_A, 8'h00);
        wr_reg(`OFS_P3_CFG_A, 8'h00);
        cmp_pin(p2_pu, 8'h1F);
        cmp_pin(p3_pu, 8'h03);
        wr_reg(`OFS_P2_LATCH, 8'h0A);
        wr_reg(`OFS_P3_CFG_B, 8'hFF);
        cmp_pin(p2_out, 8'h0A);
        cmp_pin(p2_oe, 8'h15);
        cmp_pin(p3_oe, 8'h03);
        cmp_pin(p3_out, 8'h03);
        rd_chk(`OFS_P2_IN, 8'h0A);
        rd_chk(`OFS_P3_IN, 8'h03);
        rd_chk(`OFS_P2_CFG_B, 8'h00);
        rd_chk(`OFS_P3_CFG_B, 8'h03);
        $display("test restricted pins done");
        @(posedge clock);
        x0 <= 8'h10;
        repeat (3) @(posedge clock);
        rd_chk(`OFS_P0_IN, 8'hE4);
        wr_reg(`OFS_P0_CFG_A, 8'hFF);
        wr_reg(`OFS_P0_CFG_B, 8'h00);
        cmp_pin(p0_oe | p0_pu, 8'h00);
        x0 <= 8'h21;
        wr_reg(`OFS_P0_ANA_DIS, 8'hFF);
        rd_chk(`OFS_P0_ANA_DIS, 8'h3E);
        rd_chk(`OFS_P0_IN, 8'hC0);
        $display("test inputs done");
        wr_reg(`OFS_USER_CFG1, 8'h01);
        x1 <= 8'h20;
        repeat (3) @(posedge clock);
        #1;
        cmp_pin({7'h00, ext_req}, 8'h01);
        rd_chk(`OFS_P1_IN, 8'hDF);
        wr_reg(`OFS_USER_CFG1, 8'h00);
        repeat (3) @(posedge clock);
        #1;
        cmp_pin({7'h00, ext_req}, 8'h00);
        $display("test reset pin done");
        @(posedge clock);
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        rd_chk(`OFS_P0_ANA_DIS, 8'h00);
        cmp_pin(p0_oe | p1_oe | p0_pu | p1_pu, 8'h00);
        cmp_pin({7'h00, ext_req}, 8'h00);
        rd_chk(`OFS_USER_CFG1, 8'h00);
        rd_chk(`OFS_P1_CFG_A, 8'hFF);
        $display("test second reset done");
        final_report();
    end
endmodule
`default_nettype wire
